// File: core/cpaw_params.svh
`ifndef CPAW_PARAMS_SVH
`define CPAW_PARAMS_SVH
`define CPAW_CLK_NS        10
`define CPAW_CPU_PERIOD_NS 100
`define CPAW_CPU_DIV       (`CPAW_CPU_PERIOD_NS / `CPAW_CLK_NS)
`define CPAW_BASE_STATES   2
`define CPAW_RAM_WAITS     1
`define CPAW_IO_WAITS      1
`define CPAW_ROM_WAITS     2
`define CPAW_DMA_CYCLE_NS  1000
`define CPAW_DMA_TICKS     (`CPAW_DMA_CYCLE_NS / `CPAW_CPU_PERIOD_NS)
`define CPAW_REF_PERIOD    100
`define CPAW_REF_TICKS     3
`define CPAW_DESC_BYTES    8
`define CPAW_ROM_BASE      24'hFC_0000
`define CPAW_RAM_TOP       24'h10_0000
`define CPAW_SEG_LAST      16'hFFFF
`endif

// File: core/cpaw_pkg.sv
package cpaw_pkg;
  typedef enum logic [1:0] {CPAW_RAM, CPAW_ROM, CPAW_IO, CPAW_DMA}
    cpaw_space_type;
  typedef struct packed {
    logic [15:0] selector;
    logic [15:0] offset;
  } cpaw_ptr_type;
  typedef struct packed {
    logic        present;
    logic [23:0] base;
  } cpaw_desc_type;
endpackage

// File: core/cpaw_core.sv
`timescale 1ns/1ns
`include "cpaw_params.svh"
module cpaw_core
  import cpaw_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // Address request.
  input  wire logic          req_i,
  input  wire logic          prot_i,
  input  wire logic          word_i,
  input  wire logic          seg_load_i,
  input  wire cpaw_ptr_type  ptr_i,
  input  wire cpaw_space_type space_i,
  // Descriptor table answer.
  input  wire logic          desc_valid_i,
  input  wire cpaw_desc_type desc_i,
  // Results.
  output logic [23:0]        addr_o,
  output logic               addr_valid_o,
  output logic               fault_o,
  output logic               desc_fetch_o,
  output logic [2:0]         desc_byte_o,
  output logic               cyc_done_o,
  output logic               cpu_tick_o,
  output logic               dma_tick_o,
  output logic               refresh_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} cpaw_state_type;

  // Number of processor states for a bus cycle in a given space.
  function automatic logic [3:0] cyc_states(input cpaw_space_type s);
    case (s)
      CPAW_RAM: cyc_states = 4'(`CPAW_BASE_STATES + `CPAW_RAM_WAITS);
      CPAW_ROM: cyc_states = 4'(`CPAW_BASE_STATES + `CPAW_ROM_WAITS);
      CPAW_IO:  cyc_states = 4'(`CPAW_BASE_STATES + `CPAW_IO_WAITS);
      default:  cyc_states = 4'(`CPAW_DMA_TICKS);
    endcase
  endfunction

  cpaw_state_type state, next_state;
  logic [3:0]  div, next_div;
  logic [3:0]  wcnt, next_wcnt;
  logic        dma_ph, next_dma_ph;
  logic [6:0]  ref_cnt, next_ref_cnt;
  logic [23:0] cache_base, next_cache_base;
  logic        cache_ok, next_cache_ok;
  logic [2:0]  dbyte, next_dbyte;
  logic [23:0] next_addr;
  logic        next_addr_valid, next_fault, next_fetch, next_done;
  logic        next_cpu_tick, next_dma_tick, next_refresh;
  cpaw_space_type space, next_space;
  logic [15:0] off, next_off;
  logic        wrd, next_wrd;
  logic        tick;
  logic [23:0] real_addr;

  assign tick = (div == 4'(`CPAW_CPU_DIV - 1));
  // Segment shift plus offset; low nibble zero; the carry into bit 20 is kept.
  assign real_addr = {4'h0, ptr_i.selector, 4'h0} + {8'h00, ptr_i.offset};

  // Base timing runs free of requests, so a bus cycle starts anywhere inside
  // a processor state and its first state may be cut short.
  always_comb begin
    next_div      = tick ? 4'h0 : div + 4'h1;
    next_dma_ph   = dma_ph;
    next_ref_cnt  = ref_cnt;
    next_cpu_tick = tick;
    next_dma_tick = 1'b0;
    next_refresh  = refresh_o;
    if (tick) begin
      next_dma_ph   = ~dma_ph;
      next_dma_tick = dma_ph;
      next_ref_cnt  = (ref_cnt == 7'(`CPAW_REF_PERIOD - 1)) ?
                      7'h00 : ref_cnt + 7'h01;
      next_refresh  = (ref_cnt < 7'(`CPAW_REF_TICKS));
    end
  end

  // Timing registers; the enable freezes them with the rest of the block.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div        <= 4'h0;
      dma_ph     <= 1'b0;
      ref_cnt    <= 7'h00;
      cpu_tick_o <= 1'b0;
      dma_tick_o <= 1'b0;
      refresh_o  <= 1'b0;
    end else if (ce_i) begin
      div        <= next_div;
      dma_ph     <= next_dma_ph;
      ref_cnt    <= next_ref_cnt;
      cpu_tick_o <= next_cpu_tick;
      dma_tick_o <= next_dma_tick;
      refresh_o  <= next_refresh;
    end
  end

  // Next-state logic for translation and wait states.
  always_comb begin
    next_state      = state;
    next_wcnt       = wcnt;
    next_cache_base = cache_base;
    next_cache_ok   = cache_ok;
    next_dbyte      = dbyte;
    next_addr       = addr_o;
    next_addr_valid = 1'b0;
    next_fault      = 1'b0;
    next_fetch      = desc_fetch_o;
    next_done       = 1'b0;
    next_space      = space;
    next_off        = off;
    next_wrd        = wrd;
    case (state)
      ST_IDLE: begin
        if (req_i && prot_i && (seg_load_i || !cache_ok)) begin
          next_state = ST_FETCH;
          next_fetch = 1'b1;
          next_dbyte = 3'h0;
          next_off   = ptr_i.offset;
          next_space = space_i;
          next_wrd   = word_i;
        end else if (req_i) begin
          next_space = space_i;
          next_wrd   = word_i;
          next_off   = ptr_i.offset;
          if (word_i && ptr_i.offset == `CPAW_SEG_LAST) begin
            next_fault = 1'b1;
          end else begin
            // Any access allowed; base plus offset.
            next_addr  = prot_i ? cache_base + {8'h00, ptr_i.offset}
                                : real_addr;
            next_state = ST_WAIT;
            next_wcnt  = 4'h0;
          end
        end
      end
      ST_FETCH: begin
        if (tick && dbyte != 3'(`CPAW_DESC_BYTES - 1)) begin
          next_dbyte = dbyte + 3'h1;
        end
        if (desc_valid_i && dbyte == 3'(`CPAW_DESC_BYTES - 1)) begin
          next_fetch = 1'b0;
          if (!desc_i.present) begin
            next_fault    = 1'b1;
            next_cache_ok = 1'b0;
            next_state    = ST_IDLE;
          end else begin
            next_cache_base = desc_i.base;
            next_cache_ok   = 1'b1;
            next_addr  = desc_i.base + {8'h00, off};
            next_state = ST_WAIT;
            next_wcnt  = 4'h0;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          next_wcnt = wcnt + 4'h1;
          if (wcnt + 4'h1 == cyc_states(space)) begin
            next_addr_valid = 1'b1;
            next_done       = 1'b1;
            next_state      = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Translation register stage; the enable freezes everything.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state        <= ST_IDLE;
      wcnt         <= 4'h0;
      cache_base   <= 24'h00_0000;
      cache_ok     <= 1'b0;
      dbyte        <= 3'h0;
      addr_o       <= 24'h00_0000;
      addr_valid_o <= 1'b0;
      fault_o      <= 1'b0;
      desc_fetch_o <= 1'b0;
      cyc_done_o   <= 1'b0;
      space        <= CPAW_RAM;
      off          <= 16'h0000;
      wrd          <= 1'b0;
    end else if (ce_i) begin
      state        <= next_state;
      wcnt         <= next_wcnt;
      cache_base   <= next_cache_base;
      cache_ok     <= next_cache_ok;
      dbyte        <= next_dbyte;
      addr_o       <= next_addr;
      addr_valid_o <= next_addr_valid;
      fault_o      <= next_fault;
      desc_fetch_o <= next_fetch;
      cyc_done_o   <= next_done;
      space        <= next_space;
      off          <= next_off;
      wrd          <= next_wrd;
    end
  end

  assign desc_byte_o = dbyte;

endmodule

// File: tb/cpaw_core_properties.sv
`timescale 1ns/1ns
module cpaw_core_props
  import cpaw_pkg::*;
(
  // Clock and request.
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         req_i,
  input wire logic         prot_i,
  input wire logic         word_i,
  input wire cpaw_ptr_type ptr_i,
  // Results.
  input wire logic [23:0]  addr_o,
  input wire logic         addr_valid_o,
  input wire logic         fault_o,
  input wire logic         desc_fetch_o,
  input wire logic [2:0]   desc_byte_o,
  input wire logic         cyc_done_o,
  input wire logic         cpu_tick_o,
  input wire logic         dma_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Tick spacing assumes the enable is held high throughout.
  AST_CPU_TICK: assert property (cpu_tick_o |-> ##10 cpu_tick_o)
    else $error("cpu tick period wrong");
  AST_CPU_GAP: assert property (cpu_tick_o |=> !cpu_tick_o [*8])
    else $error("cpu tick too early");
  AST_DMA_TICK: assert property (dma_tick_o |-> ##20 dma_tick_o)
    else $error("dma tick period wrong");
  AST_DONE_VALID: assert property (cyc_done_o |-> addr_valid_o)
    else $error("done without valid address");
  AST_FAULT_PULSE: assert property (fault_o |=> !fault_o)
    else $error("fault longer than one cycle");
  AST_ADDR_STABLE: assert property (cyc_done_o |-> $stable(addr_o))
    else $error("address moved at cycle end");
  AST_WRAP_FAULT: assert property ($rose(req_i) && word_i && !prot_i
    && ptr_i.offset == 16'hFFFF |-> ##[1:2] fault_o)
    else $error("no fault on segment wrap");
  AST_DESC_STEP: assert property (desc_fetch_o && $past(desc_fetch_o)
    && desc_byte_o != $past(desc_byte_o)
    |-> desc_byte_o == $past(desc_byte_o) + 3'h1)
    else $error("descriptor byte skipped");
  // Main scenarios reached.
  COV_PROT: cover property (cyc_done_o && prot_i);
  COV_FAULT: cover property (fault_o);
  COV_LAST: cover property (desc_fetch_o && desc_byte_o == 3'h7);
endmodule
bind cpaw_core cpaw_core_props u_props (.clk_i, .rst_n_i, .req_i,
  .prot_i, .word_i, .ptr_i, .addr_o, .addr_valid_o, .fault_o,
  .desc_fetch_o, .desc_byte_o, .cyc_done_o, .cpu_tick_o, .dma_tick_o);

// File: tb/cpaw_desc_model.sv
`timescale 1ns/1ns
module cpaw_desc_model
  import cpaw_pkg::*;
(
  // Clock and fetch status.
  input  wire logic          clk_i,
  input  wire logic          fetch_i,
  input  wire logic [2:0]    byte_i,
  // Entry content and answer speed.
  input  wire cpaw_desc_type entry_i,
  input  wire logic          slow_i,
  // Answer to the core.
  output logic               valid_o,
  output cpaw_desc_type      desc_o
);
  logic [2:0] wait_q = 3'h0;
  initial valid_o = 1'b0;
  initial desc_o = '0;
  // entry on last byte
  // Outside the answer the bus toggles, so a stale entry is never seen.
  always @(posedge clk_i) begin
    wait_q <= (fetch_i && byte_i == 3'h7) ? wait_q + 3'h1 : 3'h0;
    valid_o <= fetch_i && byte_i == 3'h7 && (!slow_i || wait_q[2]);
    desc_o <= (fetch_i && byte_i == 3'h7) ? entry_i : ~desc_o;
  end
endmodule

// File: tb/cpaw_core_tb_top.sv
`timescale 1ns/1ns
module cpaw_core_tb_top;
  import cpaw_pkg::*;
  logic clk_i = 0, rst_n_i = 0, req_i = 0, prot_i = 0, word_i = 0;
  logic seg_load_i = 0, slow = 0, desc_valid_i, f;
  logic addr_valid_o, fault_o, desc_fetch_o, cyc_done_o, cpu_tick_o;
  logic dma_tick_o, refresh_o;
  logic [23:0] addr_o;
  logic [2:0] desc_byte_o, fb;
  cpaw_ptr_type ptr_i = '0;
  cpaw_space_type space_i = CPAW_RAM;
  cpaw_desc_type desc_i, entry = '0;
  int n, checked = 0, n_errors = 0;
  cpaw_core DUT (.clk_i, .rst_n_i, .ce_i(1'b1), .req_i, .prot_i,
    .word_i, .seg_load_i, .ptr_i, .space_i, .desc_valid_i, .desc_i,
    .addr_o, .addr_valid_o, .fault_o, .desc_fetch_o, .desc_byte_o,
    .cyc_done_o, .cpu_tick_o, .dma_tick_o, .refresh_o);
  cpaw_desc_model u_model (.clk_i, .fetch_i(desc_fetch_o),
    .byte_i(desc_byte_o), .entry_i(entry), .slow_i(slow),
    .valid_o(desc_valid_i), .desc_o(desc_i));
  // Free-running clock.
  initial forever #5 clk_i = ~clk_i;
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] g, e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One request; waits for done or fault and counts the cycles.
  task automatic cyc(input cpaw_ptr_type p, input cpaw_space_type s,
                     input logic pr, w, ld);
    n = 0;
    fb = 3'h0;
    ptr_i = p;
    space_i = s;
    prot_i = pr;
    word_i = w;
    seg_load_i = ld;
    req_i = 1'b1;
    @(posedge clk_i);
    #1 req_i = 1'b0;
    while (cyc_done_o !== 1'b1 && fault_o !== 1'b1 && n < 600) begin
      if (desc_fetch_o === 1'b1) fb = desc_byte_o;
      @(posedge clk_i);
      #1 n++;
    end
    f = fault_o;
    if (n >= 600) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic rt(input cpaw_ptr_type p, input cpaw_space_type s,
                    input int st, input logic [23:0] a);
    cyc(p, s, 1'b0, 1'b0, 1'b0);
    chk("addr", addr_o, a);
    chk("len", 24'(n >= st*10-10 && n <= st*10+10), 24'h1);
  endtask
  task automatic t_spaces();
    rt({16'h1234, 16'h5678}, CPAW_RAM, 3, 24'h01_79B8);
    rt({16'hF000, 16'hFFFF}, CPAW_ROM, 4, 24'h0F_FFFF);
    rt({16'h0000, 16'h03F8}, CPAW_IO, 3, 24'h00_03F8);
    rt({16'h8000, 16'h0010}, CPAW_DMA, 10, 24'h08_0010);
    $display("t_spaces done");
  endtask
  task automatic t_wrap();
    cyc({16'h2000, 16'hFFFF}, CPAW_RAM, 1'b0, 1'b1, 1'b0);
    chk("wrap fault", 24'(f), 24'h1);
    rt({16'h2000, 16'hFFFF}, CPAW_RAM, 3, 24'h02_FFFF);
    $display("t_wrap done");
  endtask
  task automatic t_prot();
    entry = {1'b1, 24'h12_3450};
    cyc({16'h0008, 16'h0010}, CPAW_RAM, 1'b1, 1'b0, 1'b1);
    chk("prot addr", addr_o, 24'h12_3460);
    chk("last byte", 24'(fb), 24'h7);
    cyc({16'h0008, 16'h0020}, CPAW_RAM, 1'b1, 1'b0, 1'b0);
    chk("cached addr", addr_o, 24'h12_3470);
    slow = 1'b1;
    entry = {1'b0, 24'h00_0100};
    cyc({16'h0010, 16'h0000}, CPAW_RAM, 1'b1, 1'b0, 1'b1);
    chk("absent fault", 24'(f), 24'h1);
    $display("t_prot done");
  endtask
  // Counts timing pulses over 1000 clocks, one refresh period.
  task automatic t_rates();
    int nc, nd, nr;
    nc = 0;
    nd = 0;
    nr = 0;
    repeat (1000) begin
      @(posedge clk_i);
      #1;
      nc += int'(cpu_tick_o === 1'b1);
      nd += int'(dma_tick_o === 1'b1);
      nr += int'(refresh_o === 1'b1);
    end
    chk("cpu ticks", 24'(nc), 24'h00_0064);
    chk("dma ticks", 24'(nd), 24'h00_0032);
    chk("refresh clocks", 24'(nr), 24'h00_001E);
    $display("t_rates done");
  endtask
  // Reset for eight cycles, then the scenarios.
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_spaces();
    t_wrap();
    t_prot();
    t_rates();
    end_sim();
  end
endmodule
